// *** rtl/detector_pkg.sv ***
/*
  Shared types and constants of the detector supervisory block.
  Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package detector_pkg;

  // Register byte offsets
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_HOLD = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_BRIGHT = 4'hC;

  // Values after reset
  localparam logic [31:0] CONFIG_RST = 32'h0000_1000;
  localparam logic [31:0] HOLD_RST = 32'h0000_003C;
  localparam logic [31:0] BRIGHT_RST = 32'h0000_0000;
  localparam logic [7:0] FACTOR_RST = 8'h01;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Hold-delay tick: one millisecond
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES_DFLT = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_MOTION = 3'h2,
    ST_DISABLED = 3'h4
  } st_t;

  typedef enum logic [1:0] {
    END_NONE = 2'h0,
    END_AS_END = 2'h1,
    END_AS_BEGIN = 2'h2,
    END_RESTORE = 2'h3
  } end_react_t;

  typedef enum logic [1:0] {
    RS_NONE = 2'h0,
    RS_DISABLED = 2'h1,
    RS_DETECT = 2'h2,
    RS_RESTORE = 2'h3
  } restart_t;

  typedef enum logic [1:0] {
    FB_STANDALONE = 2'h0,
    FB_MASTER = 2'h1,
    FB_EXTENSION = 2'h2,
    FB_RSVD = 2'h3
  } fb_type_t;

  // CONFIG register layout, bit 0 last
  typedef struct packed {
    logic [18:0] rsvd;
    logic fb_active;
    fb_type_t fb_type;
    logic inh_tgm_en;
    logic inh_pol;
    restart_t dl_react;
    restart_t ret_react;
    end_react_t end_react;
    logic bright_dep;
    logic lc_mode;
  } cfg_t;

  // STATUS register layout, bit 0 last
  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] factor;
    logic [4:0] rsvd_lo;
    logic swoff_wait;
    logic bright_indep;
    logic lc_inhibit;
    logic presence;
    logic hold_run;
    st_t saved;
    st_t state;
  } status_t;

endpackage

// *** rtl/detector_supervisor.sv ***
/*
  Supervisory state logic of one motion-detection function block:
  disable start and end, light-control disable path, restart after
  supply return and after configuration download.
  Assumes event strobes are one-cycle pulses from logic on CLK.
*/
`timescale 1ns/100ps
module detector_supervisor
  import detector_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
  parameter int HOLD_W = 24
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // AXI4-Lite write
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Restart events
  input wire logic SUPPLY_RETURN,
  input wire logic DOWNLOAD_DONE,
  // Incoming telegrams
  input wire logic INHIBIT_STB,
  input wire logic INHIBIT_VAL,
  input wire logic MOTION_STB,
  input wire logic EXT_MOTION_STB,
  input wire logic MANUAL_STB,
  input wire logic FACTOR_STB,
  input wire logic [7:0] FACTOR_VAL,
  input wire logic [15:0] BRIGHTNESS,
  // Outgoing telegram requests
  output logic START_TGM,
  output logic END_TGM,
  output logic INHIBIT_TGM,
  // Light control and status
  output logic LC_PRESENCE,
  output logic LC_INHIBIT,
  output logic MOTION_ACTIVE,
  output logic BRIGHT_INDEP,
  output logic SWOFF_RESTART
);

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [HOLD_W-1:0] hold_len(input logic [15:0] base,
      input logic [7:0] factor);
    logic [15:0] b;
    logic [7:0] f;
    b = (base == 16'h0000) ? 16'h0001 : base;
    f = (factor == 8'h00) ? 8'h01 : factor;
    return HOLD_W'(b * f);
  endfunction

  logic rst_meta_q;
  logic rst_n;
  logic [31:0] config_q;
  logic [31:0] hold_base_q;
  logic [31:0] bright_q;
  cfg_t cfg;
  status_t status;
  st_t st_q;
  st_t st_d;
  st_t save_q;
  st_t save_d;
  logic pres_q, pres_d;
  logic lcinh_q, lcinh_d;
  logic bi_q, bi_d;
  logic swoff_q, swoff_set;
  logic start_p, end_p, inh_p;
  logic hold_ld, hold_clr;
  logic hold_run_q;
  logic [HOLD_W-1:0] hold_cnt_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic hold_done;
  logic [7:0] factor_q;
  logic start_q, end_q, inh_q, swoff_pulse_q;
  logic tgm_ok, type_ok, ret_go, dl_go, inh_on, motion_in;
  restart_t rs;
  end_react_t er;
  logic restore_hit;
  logic aw_hold_q, w_hold_q;
  logic [3:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have, w_have, wr_fire;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // Reset release through two flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  assign cfg = cfg_t'(config_q);
  assign type_ok = (cfg.fb_type == FB_STANDALONE) ||
                   (cfg.fb_type == FB_MASTER);
  // Light control sends its own telegrams, so the block stays quiet
  assign tgm_ok = !cfg.lc_mode && type_ok;
  assign dl_go = DOWNLOAD_DONE && cfg.fb_active && type_ok;
  assign ret_go = SUPPLY_RETURN && cfg.fb_active && !dl_go;
  assign inh_on = INHIBIT_VAL ^ cfg.inh_pol;
  assign motion_in = MOTION_STB || EXT_MOTION_STB || MANUAL_STB;

  // Hold-delay prescaler and counter
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  assign hold_done = hold_run_q && tick && (hold_cnt_q <= HOLD_W'(1));

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (!hold_run_q || hold_ld || tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      hold_run_q <= 1'b0;
      hold_cnt_q <= '0;
    end else if (hold_ld) begin
      hold_run_q <= 1'b1;
      hold_cnt_q <= hold_len(hold_base_q[15:0], factor_q);
    end else if (hold_clr || hold_done) begin
      hold_run_q <= 1'b0;
      hold_cnt_q <= '0;
    end else if (hold_run_q && tick) begin
      hold_cnt_q <= hold_cnt_q - HOLD_W'(1);
    end
  end

  // Factor is taken in every state, disabled included
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      factor_q <= FACTOR_RST;
    end else if (FACTOR_STB) begin
      factor_q <= FACTOR_VAL;
    end
  end

  // Supervisory decisions; restart wins over telegrams, motion over expiry
  always_comb begin
    st_d = st_q;
    save_d = save_q;
    pres_d = pres_q;
    lcinh_d = lcinh_q;
    bi_d = bi_q;
    swoff_set = 1'b0;
    start_p = 1'b0;
    end_p = 1'b0;
    inh_p = 1'b0;
    hold_ld = 1'b0;
    hold_clr = 1'b0;
    restore_hit = 1'b0;
    rs = RS_NONE;
    er = END_NONE;
    if (ret_go || dl_go) begin
      rs = dl_go ? cfg.dl_react : cfg.ret_react;
      if (rs == RS_RESTORE) begin
        if (dl_go) begin
          rs = RS_NONE;
        end else begin
          unique case (st_q)
            ST_IDLE: rs = RS_NONE;
            ST_DISABLED: rs = RS_DISABLED;
            ST_MOTION: begin
              rs = RS_DETECT;
              restore_hit = !cfg.lc_mode;
            end
          endcase
        end
      end
      unique case (rs)
        RS_NONE: begin
          st_d = ST_IDLE;
          hold_clr = 1'b1;
          pres_d = 1'b0;
          lcinh_d = 1'b0;
        end
        RS_DISABLED: begin
          st_d = ST_DISABLED;
          save_d = ST_IDLE;
          hold_clr = 1'b1;
          pres_d = 1'b0;
          lcinh_d = cfg.lc_mode;
          inh_p = tgm_ok && cfg.inh_tgm_en;
        end
        RS_DETECT, RS_RESTORE: begin
          st_d = ST_MOTION;
          hold_ld = 1'b1;
          lcinh_d = 1'b0;
          pres_d = cfg.lc_mode;
          start_p = tgm_ok;
          bi_d = restore_hit || !cfg.bright_dep ||
                 (BRIGHTNESS < bright_q[15:0]);
          swoff_set = restore_hit;
        end
      endcase
    end else if (INHIBIT_STB) begin
      if (inh_on) begin
        if (st_q != ST_DISABLED) begin
          save_d = st_q;
        end
        // Repeated disable repeats the start reaction
        st_d = ST_DISABLED;
        hold_clr = 1'b1;
        lcinh_d = cfg.lc_mode;
        inh_p = tgm_ok && cfg.inh_tgm_en;
      end else if (st_q == ST_DISABLED) begin
        lcinh_d = 1'b0;
        if (cfg.lc_mode) begin
          st_d = ST_IDLE;
          hold_clr = 1'b1;
          pres_d = 1'b1;
        end else begin
          er = (cfg.fb_type == FB_EXTENSION) ? END_NONE : cfg.end_react;
          if (er == END_RESTORE) begin
            er = (save_q == ST_MOTION) ? END_AS_BEGIN : END_AS_END;
          end
          unique case (er)
            END_NONE: begin
              st_d = ST_IDLE;
              hold_clr = 1'b1;
            end
            END_AS_END: begin
              st_d = ST_IDLE;
              hold_clr = 1'b1;
              end_p = tgm_ok;
            end
            END_AS_BEGIN, END_RESTORE: begin
              st_d = ST_MOTION;
              hold_ld = 1'b1;
              start_p = tgm_ok;
            end
          endcase
        end
      end
      // Enable while not disabled falls through unanswered
    end else if (motion_in && st_q != ST_DISABLED) begin
      start_p = tgm_ok && (st_q == ST_IDLE);
      st_d = ST_MOTION;
      hold_ld = 1'b1;
      pres_d = cfg.lc_mode;
    end else if (st_q == ST_MOTION && hold_done) begin
      st_d = ST_IDLE;
      end_p = tgm_ok;
      pres_d = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      save_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
      save_q <= save_d;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pres_q <= 1'b0;
      lcinh_q <= 1'b0;
      bi_q <= 1'b1;
    end else begin
      pres_q <= pres_d;
      lcinh_q <= lcinh_d;
      bi_q <= bi_d;
    end
  end

  // Switch-off delay stays parked until brightness climbs again
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      swoff_q <= 1'b0;
      swoff_pulse_q <= 1'b0;
    end else begin
      swoff_pulse_q <= 1'b0;
      if (swoff_set) begin
        swoff_q <= 1'b1;
      end else if (swoff_q && BRIGHTNESS > bright_q[31:16]) begin
        swoff_q <= 1'b0;
        swoff_pulse_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      end_q <= 1'b0;
      inh_q <= 1'b0;
    end else begin
      start_q <= start_p;
      end_q <= end_p;
      inh_q <= inh_p;
    end
  end

  assign START_TGM = start_q;
  assign END_TGM = end_q;
  assign INHIBIT_TGM = inh_q;
  assign LC_PRESENCE = pres_q;
  assign LC_INHIBIT = lcinh_q;
  assign MOTION_ACTIVE = (st_q == ST_MOTION);
  assign BRIGHT_INDEP = bi_q;
  assign SWOFF_RESTART = swoff_pulse_q;

  // AXI4-Lite write: address and data taken in either order
  assign S_AXI_AWREADY = !aw_hold_q && !bvalid_q;
  assign S_AXI_WREADY = !w_hold_q && !bvalid_q;
  assign aw_have = aw_hold_q || (S_AXI_AWVALID && S_AXI_AWREADY);
  assign w_have = w_hold_q || (S_AXI_WVALID && S_AXI_WREADY);
  assign wr_fire = aw_have && w_have && !bvalid_q;
  assign wr_addr = aw_hold_q ? aw_addr_q : S_AXI_AWADDR;
  assign wr_data = w_hold_q ? wdata_q : S_AXI_WDATA;
  assign wr_strb = w_hold_q ? wstrb_q : S_AXI_WSTRB;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      config_q <= CONFIG_RST;
      hold_base_q <= HOLD_RST;
      bright_q <= BRIGHT_RST;
    end else if (wr_fire) begin
      unique case ({wr_addr[3:2], 2'b00})
        ADDR_CONFIG: config_q <= merge_strb(config_q, wr_data, wr_strb);
        ADDR_HOLD: hold_base_q <= merge_strb(hold_base_q, wr_data, wr_strb);
        ADDR_BRIGHT: bright_q <= merge_strb(bright_q, wr_data, wr_strb);
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_addr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  always_comb begin
    status = '0;
    status.state = st_q;
    status.saved = save_q;
    status.hold_run = hold_run_q;
    status.presence = pres_q;
    status.lc_inhibit = lcinh_q;
    status.bright_indep = bi_q;
    status.swoff_wait = swoff_q;
    status.factor = factor_q;
  end

  // AXI4-Lite read, answered one cycle after the address
  assign S_AXI_ARREADY = !rvalid_q;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= (S_AXI_ARADDR[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
      unique case ({S_AXI_ARADDR[3:2], 2'b00})
        ADDR_CONFIG: rdata_q <= {13'h0, config_q[18:0]};
        ADDR_HOLD: rdata_q <= {16'h0000, hold_base_q[15:0]};
        ADDR_STATUS: rdata_q <= status;
        ADDR_BRIGHT: rdata_q <= bright_q;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;

endmodule

// *** testbench/detector_supervisor_monitor.sv ***
/*
  Port checker for detector_supervisor, bound to every instance.
  Assumes all strobes and outputs are synchronous to CLK.
*/
`timescale 1ns/100ps
module detector_supervisor_monitor (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Events
  input wire logic INHIBIT_STB,
  input wire logic MOTION_STB,
  input wire logic EXT_MOTION_STB,
  input wire logic MANUAL_STB,
  input wire logic SUPPLY_RETURN,
  input wire logic DOWNLOAD_DONE,
  // Outputs
  input wire logic START_TGM,
  input wire logic END_TGM,
  input wire logic INHIBIT_TGM,
  input wire logic LC_PRESENCE,
  input wire logic LC_INHIBIT,
  input wire logic MOTION_ACTIVE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic restart;
  logic any_motion;
  assign restart = SUPPLY_RETURN || DOWNLOAD_DONE;
  assign any_motion = MOTION_STB || EXT_MOTION_STB || MANUAL_STB;

  a_start_single: assert property (START_TGM |=> !START_TGM)
    else $error("start telegram longer than one cycle");
  a_start_motion: assert property (START_TGM |-> MOTION_ACTIVE)
    else $error("start telegram without detection");
  a_end_idle: assert property (END_TGM |-> !MOTION_ACTIVE)
    else $error("end telegram while detection runs");
  a_start_cause: assert property (START_TGM |->
    $past(INHIBIT_STB || any_motion || restart))
    else $error("start telegram without a cause");
  a_inh_cause: assert property (INHIBIT_TGM |->
    $past(INHIBIT_STB || restart))
    else $error("disable telegram without a cause");
  a_inh_frozen: assert property (INHIBIT_TGM |->
    !MOTION_ACTIVE && !LC_INHIBIT)
    else $error("disable telegram with detection or light control");
  a_lc_quiet: assert property (LC_INHIBIT |->
    !MOTION_ACTIVE && !START_TGM && !END_TGM)
    else $error("activity while light control disabled");
  a_lc_ignore: assert property (LC_INHIBIT && any_motion && !INHIBIT_STB
    && !restart |=> LC_INHIBIT && !MOTION_ACTIVE)
    else $error("motion accepted while disabled");
  a_lc_release: assert property ($fell(LC_INHIBIT) && $past(INHIBIT_STB)
    && !$past(restart) |-> LC_PRESENCE && !MOTION_ACTIVE)
    else $error("light control enable without presence");

  c_start: cover property (START_TGM);
  c_end: cover property (END_TGM);
  c_inh: cover property (INHIBIT_TGM);
  c_lc: cover property ($rose(LC_INHIBIT));
endmodule

bind detector_supervisor detector_supervisor_monitor
  u_detector_supervisor_monitor (.CLK, .RST_B, .INHIBIT_STB, .MOTION_STB,
  .EXT_MOTION_STB, .MANUAL_STB, .SUPPLY_RETURN, .DOWNLOAD_DONE, .START_TGM,
  .END_TGM, .INHIBIT_TGM, .LC_PRESENCE, .LC_INHIBIT, .MOTION_ACTIVE);

// *** testbench/bus_actuator_model.sv ***
/*
  Far side: bus actuators, counting telegram requests.
  Assumes one-cycle request pulses on clk.
*/
`timescale 1ns/100ps
module bus_actuator_model (
  // Clock
  input wire logic clk,
  // Telegram requests
  input wire logic start_tgm,
  input wire logic end_tgm,
  input wire logic inhibit_tgm,
  // Telegrams sent so far
  output int n_start,
  output int n_end,
  output int n_inh
);
  // One process, so each count has a single driver
  initial begin
    n_start = 0;
    n_end = 0;
    n_inh = 0;
    forever begin
      @(posedge clk);
      if (start_tgm === 1'b1) n_start++;
      if (end_tgm === 1'b1) n_end++;
      if (inhibit_tgm === 1'b1) n_inh++;
    end
  end
endmodule

// *** testbench/detector_supervisor_tb.sv ***
/*
  Self-checking bench for detector_supervisor.
  Assumes the bound monitor and the actuator model beside it.
*/
`timescale 1ns/100ps
module detector_supervisor_tb
  import detector_pkg::*;
;
  localparam int TICK = 4;
  localparam int HOLD_CYC = TICK * 2 * 3;
  localparam logic [6:0] S_INH = 7'h01;
  localparam logic [6:0] S_MOT = 7'h02;
  localparam logic [6:0] S_EXT = 7'h04;
  localparam logic [6:0] S_MAN = 7'h08;
  localparam logic [6:0] S_SUP = 7'h10;
  localparam logic [6:0] S_DL = 7'h20;
  localparam logic [6:0] S_FAC = 7'h40;
  logic clk, rst_b, ival;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [6:0] stb;
  logic start_tgm, end_tgm, inhibit_tgm, lc_presence, lc_inhibit;
  logic motion_active, bright_indep, swoff_restart;
  logic [15:0] bright;
  int n_start, n_end, n_inh, s0, e0, i0;
  int mismatches = 0;
  int checks_done = 0;

  detector_supervisor #(.TICK_CYCLES(TICK)) u_detector_supervisor (
    .CLK(clk), .RST_B(rst_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SUPPLY_RETURN(stb[4]), .DOWNLOAD_DONE(stb[5]), .INHIBIT_STB(stb[0]),
    .INHIBIT_VAL(ival), .MOTION_STB(stb[1]), .EXT_MOTION_STB(stb[2]),
    .MANUAL_STB(stb[3]), .FACTOR_STB(stb[6]), .FACTOR_VAL(8'h03),
    .BRIGHTNESS(bright), .START_TGM(start_tgm), .END_TGM(end_tgm),
    .INHIBIT_TGM(inhibit_tgm), .LC_PRESENCE(lc_presence),
    .LC_INHIBIT(lc_inhibit), .MOTION_ACTIVE(motion_active),
    .BRIGHT_INDEP(bright_indep), .SWOFF_RESTART(swoff_restart));

  bus_actuator_model u_bus_actuator_model (.clk(clk), .start_tgm(start_tgm),
    .end_tgm(end_tgm), .inhibit_tgm(inhibit_tgm), .n_start(n_start),
    .n_end(n_end), .n_inh(n_inh));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop;
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic give_up;
    chk(1'b0, "wait ran out");
    report_and_stop();
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    n = 0;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (tb !== 1'b1) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
      if (n > 50) give_up();
    end
    bready <= 1'b0;
    chk(r === RESP_OKAY, "write response");
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic tr, tv;
    int n;
    n = 0;
    tv = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (tv !== 1'b1) begin
      @(negedge clk);
      tr = arvalid & arready;
      tv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (tr) arvalid <= 1'b0;
      n++;
      if (n > 50) give_up();
    end
    rready <= 1'b0;
  endtask

  // Ends at a falling edge so outputs and counts have settled
  task automatic ev(input logic [6:0] s, input logic v);
    s0 = n_start;
    e0 = n_end;
    i0 = n_inh;
    @(posedge clk);
    stb <= s;
    ival <= v;
    @(posedge clk);
    stb <= '0;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic exp_ev(input int ds, de, di, input logic ma,
                        input string m);
    chk(n_start - s0 == ds && n_end - e0 == de && n_inh - i0 == di
        && motion_active === ma, m);
  endtask

  task automatic wait_end;
    int c;
    c = 0;
    e0 = n_end;
    while (motion_active === 1'b1) begin
      @(negedge clk);
      c++;
      if (c > 200) give_up();
    end
    @(negedge clk);
    // Prescaler restarts on each load; one tick of slack below, two cycles above
    chk(c >= HOLD_CYC - TICK && c <= HOLD_CYC + 2 && n_end - e0 == 1,
        "hold delay end");
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(ADDR_CONFIG, d, r);
    chk(d === CONFIG_RST && r === RESP_OKAY, "config reset value");
    rd(ADDR_HOLD, d, r);
    chk(d === HOLD_RST, "hold reset value");
    rd(ADDR_BRIGHT, d, r);
    chk(d === BRIGHT_RST, "bright reset value");
    rd(4'h2, d, r);
    chk(r === RESP_SLVERR, "unaligned read");
    wr(ADDR_HOLD, 32'h0000_0002);
  endtask

  task automatic t_begin;
    logic [31:0] d;
    logic [1:0] r;
    wr(ADDR_CONFIG, 32'h0000_1208);
    ev(S_INH, 1'b1);
    exp_ev(0, 0, 1, 1'b0, "disable start");
    ev(S_MOT | S_EXT | S_MAN, 1'b0);
    exp_ev(0, 0, 0, 1'b0, "motion while disabled");
    ev(S_FAC, 1'b0);
    rd(ADDR_STATUS, d, r);
    chk(d[23:16] === 8'h03, "factor while disabled");
    ev(S_INH, 1'b0);
    exp_ev(1, 0, 0, 1'b1, "enable as begin");
    wait_end();
  endtask

  task automatic t_drop;
    ev(S_INH, 1'b0);
    exp_ev(0, 0, 0, 1'b0, "enable while not disabled");
  endtask

  task automatic t_restore;
    wr(ADDR_CONFIG, 32'h0000_120C);
    ev(S_INH, 1'b1);
    ev(S_INH, 1'b0);
    exp_ev(0, 1, 0, 1'b0, "restore saved idle");
    ev(S_MOT, 1'b0);
    ev(S_INH, 1'b1);
    exp_ev(0, 0, 1, 1'b0, "disable stops detection");
    ev(S_INH, 1'b0);
    exp_ev(1, 0, 0, 1'b1, "restore saved motion");
    wait_end();
  endtask

  task automatic t_lc;
    wr(ADDR_CONFIG, 32'h0000_1101);
    ev(S_MOT, 1'b0);
    chk(motion_active === 1'b1 && lc_presence === 1'b1, "lc motion");
    ev(S_INH, 1'b0);
    chk(lc_inhibit === 1'b1 && motion_active === 1'b0, "lc disable");
    ev(S_MOT | S_MAN, 1'b0);
    chk(motion_active === 1'b0 && n_start == s0, "lc ignore");
    ev(S_INH, 1'b1);
    chk(lc_inhibit === 1'b0 && lc_presence === 1'b1
        && motion_active === 1'b0, "lc enable");
  endtask

  task automatic rs(input logic [31:0] c, input logic [6:0] s,
                    input int ds, di, input logic ma, lci, input string m);
    wr(ADDR_CONFIG, c);
    ev(s, 1'b0);
    chk(n_start - s0 == ds && n_end == e0 && n_inh - i0 == di
        && motion_active === ma && lc_inhibit === lci, m);
  endtask

  task automatic t_restart;
    rs(32'h0000_1210, S_SUP, 0, 1, 0, 0, "disabled restart");
    rs(32'h0000_1200, S_SUP, 0, 0, 0, 0, "no reaction");
    rs(32'h0000_1020, S_SUP, 1, 0, 1, 0, "detect restart");
    rs(32'h0000_1200, S_SUP, 0, 0, 0, 0, "basic from motion");
    rs(32'h0000_1011, S_SUP, 0, 0, 0, 1, "lc disabled");
    rs(32'h0000_1021, S_SUP, 0, 0, 1, 0, "lc detect");
    chk(lc_presence === 1'b1, "lc detect presence");
    rs(32'h0000_1031, S_SUP, 0, 0, 1, 0, "lc restore motion");
    chk(lc_presence === 1'b1, "lc restore presence");
    rs(32'h0000_1001, S_SUP, 0, 0, 0, 0, "lc basic");
    chk(lc_presence === 1'b0, "presence cleared");
    rs(32'h0000_0210, S_SUP, 0, 0, 0, 0, "inactive block");
    rs(32'h0000_1260, S_SUP | S_DL, 0, 1, 0, 0, "download wins");
    rs(32'h0000_1A80, S_DL, 0, 0, 0, 0, "extension download");
    rs(32'h0000_1640, S_DL, 0, 1, 0, 0, "master download");
    rs(32'h0000_1230, S_SUP, 0, 1, 0, 0, "restore disabled");
    rs(32'h0000_1200, S_SUP, 0, 0, 0, 0, "back to basic");
    ev(S_MOT, 1'b0);
    rs(32'h0000_1230, S_SUP, 1, 0, 1, 0, "restore motion");
    chk(bright_indep === 1'b1, "restore independent");
    wait_end();
  endtask

  // Parked switch-off delay, then twilight gating of BRIGHT_INDEP on detect-start
  task automatic t_bright;
    chk(swoff_restart === 1'b0, "switch-off restarted alone");
    wr(ADDR_BRIGHT, 32'h0010_0008);
    @(posedge clk);
    bright <= 16'h0020;
    @(posedge clk);
    @(negedge clk);
    chk(swoff_restart === 1'b1, "switch-off restart");
    rs(32'h0000_1022, S_SUP, 1, 0, 1, 0, "dependent bright");
    chk(bright_indep === 1'b0, "bright stays dependent");
    @(posedge clk);
    bright <= 16'h0000;
    rs(32'h0000_1022, S_SUP, 1, 0, 1, 0, "dependent dark");
    chk(bright_indep === 1'b1, "dark goes independent");
  endtask

  initial begin
    rst_b = 1'b0;
    ival = 1'b0;
    stb = '0;
    bright = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_begin();
    t_drop();
    t_restore();
    t_lc();
    t_restart();
    t_bright();
    report_and_stop();
  end
endmodule
